/* inc/ecm_pkg.sv */
`default_nettype none
package ecm_pkg;
  // Register byte addresses, one aligned word each
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_DUTY  = 8'h04;
  localparam logic [7:0] ADR_PER   = 8'h08;
  localparam logic [7:0] ADR_CCPR  = 8'h0C;
  localparam logic [7:0] ADR_TCFG  = 8'h10;
  localparam logic [7:0] ADR_STEER = 8'h14;
  localparam logic [7:0] ADR_IST   = 8'h18;
  localparam logic [7:0] ADR_IMSK  = 8'h1C;
  localparam logic [7:0] ADR_STAT  = 8'h20;
  localparam logic [7:0] ADR_FIRST_CAPTURE_TIMER  = 8'h24;
  localparam logic [7:0] ADR_TMR2  = 8'h28;

  // Control register fields
  localparam int OCFG_HI = 7;
  localparam int OCFG_LO = 6;
  localparam int DUTY_HI = 5;
  localparam int DUTY_LO = 4;
  localparam int FSEL_HI = 3;
  localparam int FSEL_LO = 0;
  localparam int POL_AC  = 1;
  localparam int POL_BD  = 0;

  // Byte lanes and other bit positions
  localparam int SEL_LO   = 0;
  localparam int SEL_HI   = 1;
  localparam int TCFG_SEL = 0;
  localparam int TCFG_T1  = 1;
  localparam int TCFG_T2  = 2;
  localparam int IST_UNIT = 0;
  localparam int IST_PER  = 1;

  // Reset values
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [7:0]  PER_RST   = 8'hFF;
  localparam logic [3:0]  STEER_RST = 4'h1;
  localparam logic [15:0] WORD_RST  = 16'h0000;

  // Output configurations
  localparam logic [1:0] OC_SINGLE = 2'h0;
  localparam logic [1:0] OC_FWD    = 2'h1;
  localparam logic [1:0] OC_HALF   = 2'h2;
  localparam logic [1:0] OC_REV    = 2'h3;

  // Function select codes
  localparam logic [3:0] FS_OFF      = 4'h0;
  localparam logic [3:0] FS_TOGGLE   = 4'h2;
  localparam logic [3:0] FS_CAP_FALL = 4'h4;
  localparam logic [3:0] FS_CAP_RISE = 4'h5;
  localparam logic [3:0] FS_CAP_R4   = 4'h6;
  localparam logic [3:0] FS_CAP_R16  = 4'h7;
  localparam logic [3:0] FS_CMP_SET  = 4'h8;
  localparam logic [3:0] FS_CMP_CLR  = 4'h9;
  localparam logic [3:0] FS_CMP_SWI  = 4'hA;
  localparam logic [3:0] FS_CMP_SPEV = 4'hB;
  localparam logic [1:0] FS_PWM_TOP  = 2'h3;

  // Capture prescale terminal counts and period timer low phase
  localparam logic [3:0] CAP_DIV4  = 4'h3;
  localparam logic [3:0] CAP_DIV16 = 4'hF;
  localparam logic [1:0] PH_LAST   = 2'h3;

  // PWM start-up states
  typedef enum logic [1:0] {PS_IDLE, PS_WAIT, PS_RUN} ecm_pwm_e;
endpackage
`default_nettype wire

/* rtl/ecm_timer16.sv */
`default_nettype none
module ecm_timer16
  import ecm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        en_i,
  input  wire logic        clr_i,
  input  wire logic        ld_i,
  input  wire logic [15:0] ld_val_i,
  // Count
  output logic      [15:0] cnt_o
);
  logic [15:0] cnt_ff;

  // Free-running counter; a software load wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= WORD_RST;
    end else if (ld_i) begin
      cnt_ff <= ld_val_i;
    end else if (clr_i) begin
      cnt_ff <= WORD_RST;
    end else if (en_i) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  assign cnt_o = cnt_ff;
endmodule
`default_nettype wire

/* rtl/ecm_unit.sv */
`default_nettype none
module ecm_unit
  import ecm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Capture input from the A pin
  input  wire logic        cap_in_i,
  // Pin values and claim flags
  output logic             out_a_o,
  output logic             out_b_o,
  output logic             out_c_o,
  output logic             out_d_o,
  output logic             own_a_o,
  output logic             own_b_o,
  output logic             own_c_o,
  output logic             own_d_o,
  // Special event pulse and interrupt
  output logic             spev_o,
  output logic             irq_o
);
  logic [7:0]  ctrl_ff;
  logic [7:0]  duty_ff;
  logic [7:0]  per_ff;
  logic [15:0] ccpr_ff;
  logic [2:0]  tcfg_ff;
  logic [3:0]  steer_ff;
  logic [1:0]  ist_ff;
  logic [1:0]  imsk_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [3:0]  fsel_prev_ff;
  logic        eq_ff;
  logic        cmp_pin_ff;
  logic        cap_prev_ff;
  logic [3:0]  cap_cnt_ff;
  logic [9:0]  tmr10_ff;
  logic [9:0]  duty_lat_ff;
  ecm_pwm_e    pwm_st_ff;
  logic        spev_ff;
  logic [3:0]  out_ff;
  logic [3:0]  own_ff;
  logic [3:0]  nxt_out;
  logic [3:0]  nxt_own;
  logic [31:0] nxt_dat;
  logic [15:0] first_capture_timer_cnt;
  logic [15:0] tmr2_cnt;
  logic [15:0] sel_cnt;
  logic [15:0] ld_val1;
  logic [15:0] ld_val2;
  logic [3:0]  fsel;
  logic [1:0]  ocfg;
  logic        wr;
  logic        is_pwm;
  logic        is_cap;
  logic        is_cmp;
  logic        enter;
  logic        match;
  logic        cap_edge;
  logic        cap_evt;
  logic        per_end;
  logic        mod;
  logic        act;
  logic        spev_hit;
  logic [1:0]  ist_set;

  // Field views and mode classes
  assign fsel   = ctrl_ff[FSEL_HI:FSEL_LO];
  assign ocfg   = ctrl_ff[OCFG_HI:OCFG_LO];
  assign is_pwm = (fsel[FSEL_HI:FSEL_HI-1] == FS_PWM_TOP);
  assign is_cap = (fsel >= FS_CAP_FALL) && (fsel <= FS_CAP_R16);
  assign is_cmp = (fsel == FS_TOGGLE) || ((fsel >= FS_CMP_SET) && (fsel <= FS_CMP_SPEV));
  assign enter  = (fsel != fsel_prev_ff);
  assign wr     = cyc_i && stb_i && we_i && ack_ff;

  // Bus answer one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= cyc_i && stb_i && !ack_ff;
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    nxt_dat = '0;
    if (adr_i == ADR_CTRL) begin
      nxt_dat[7:0] = ctrl_ff;
    end else if (adr_i == ADR_DUTY) begin
      nxt_dat[7:0] = duty_ff;
    end else if (adr_i == ADR_PER) begin
      nxt_dat[7:0] = per_ff;
    end else if (adr_i == ADR_CCPR) begin
      nxt_dat[15:0] = ccpr_ff;
    end else if (adr_i == ADR_TCFG) begin
      nxt_dat[2:0] = tcfg_ff;
    end else if (adr_i == ADR_STEER) begin
      nxt_dat[3:0] = steer_ff;
    end else if (adr_i == ADR_IST) begin
      nxt_dat[1:0] = ist_ff;
    end else if (adr_i == ADR_IMSK) begin
      nxt_dat[1:0] = imsk_ff;
    end else if (adr_i == ADR_STAT) begin
      nxt_dat[11:0] = {pwm_st_ff == PS_RUN, cmp_pin_ff, own_ff, out_ff, 2'h0};
    end else if (adr_i == ADR_FIRST_CAPTURE_TIMER) begin
      nxt_dat[15:0] = first_capture_timer_cnt;
    end else if (adr_i == ADR_TMR2) begin
      nxt_dat[15:0] = tmr2_cnt;
    end
  end

  // Read data captured in the request cycle, shown with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= '0;
    end else if (cyc_i && stb_i && !ack_ff) begin
      dat_ff <= nxt_dat;
    end
  end

  assign dat_o = dat_ff;
  assign ack_o = ack_ff;

  // Software-written configuration bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff  <= CTRL_RST;
      duty_ff  <= BYTE_RST;
      per_ff   <= PER_RST;
      tcfg_ff  <= '0;
      steer_ff <= STEER_RST;
      imsk_ff  <= '0;
    end else if (wr && sel_i[SEL_LO]) begin
      if (adr_i == ADR_CTRL) begin
        ctrl_ff <= dat_i[7:0];
      end else if (adr_i == ADR_DUTY) begin
        duty_ff <= dat_i[7:0];
      end else if (adr_i == ADR_PER) begin
        per_ff <= dat_i[7:0];
      end else if (adr_i == ADR_TCFG) begin
        tcfg_ff <= dat_i[2:0];
      end else if (adr_i == ADR_STEER) begin
        steer_ff <= dat_i[3:0];
      end else if (adr_i == ADR_IMSK) begin
        imsk_ff <= dat_i[1:0];
      end
    end
  end

  // Selected 16-bit timer base for capture and compare
  assign sel_cnt  = tcfg_ff[TCFG_SEL] ? tmr2_cnt : first_capture_timer_cnt;
  assign spev_hit = match && (fsel == FS_CMP_SPEV);
  assign ld_val1  = {sel_i[SEL_HI] ? dat_i[15:8] : first_capture_timer_cnt[15:8], sel_i[SEL_LO] ? dat_i[7:0] : first_capture_timer_cnt[7:0]};
  assign ld_val2  = {sel_i[SEL_HI] ? dat_i[15:8] : tmr2_cnt[15:8], sel_i[SEL_LO] ? dat_i[7:0] : tmr2_cnt[7:0]};

  // Two capture/compare timers
  ecm_timer16 u_first_capture_timer (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .en_i     (tcfg_ff[TCFG_T1]),
    .clr_i    (spev_hit && !tcfg_ff[TCFG_SEL]),
    .ld_i     (wr && (adr_i == ADR_FIRST_CAPTURE_TIMER)),
    .ld_val_i (ld_val1),
    .cnt_o    (first_capture_timer_cnt)
  );

  ecm_timer16 u_tmr2 (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .en_i     (tcfg_ff[TCFG_T2]),
    .clr_i    (spev_hit && tcfg_ff[TCFG_SEL]),
    .ld_i     (wr && (adr_i == ADR_TMR2)),
    .ld_val_i (ld_val2),
    .cnt_o    (tmr2_cnt)
  );

  // Compare match is the first cycle of equality
  assign match = is_cmp && (sel_cnt == ccpr_ff) && !eq_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_ff        <= 1'b0;
      fsel_prev_ff <= FS_OFF;
      spev_ff      <= 1'b0;
    end else begin
      eq_ff        <= sel_cnt == ccpr_ff;
      fsel_prev_ff <= fsel;
      spev_ff      <= spev_hit;
    end
  end

  assign spev_o = spev_ff;

  // Compare pin state on entry and on match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_pin_ff <= 1'b0;
    end else if (fsel == FS_OFF) begin
      cmp_pin_ff <= 1'b0;
    end else if (enter && (fsel == FS_CMP_SET)) begin
      cmp_pin_ff <= 1'b0;
    end else if (enter && (fsel == FS_CMP_CLR)) begin
      cmp_pin_ff <= 1'b1;
    end else if (match && (fsel == FS_CMP_SET)) begin
      cmp_pin_ff <= 1'b1;
    end else if (match && (fsel == FS_CMP_CLR)) begin
      cmp_pin_ff <= 1'b0;
    end else if (match && (fsel == FS_TOGGLE)) begin
      cmp_pin_ff <= !cmp_pin_ff;
    end
  end

  // Capture edge selection and prescale
  assign cap_edge = (fsel == FS_CAP_FALL) ? (cap_prev_ff && !cap_in_i) : (!cap_prev_ff && cap_in_i);
  assign cap_evt  = is_cap && cap_edge && (((fsel == FS_CAP_R4) && (cap_cnt_ff == CAP_DIV4))
                    || ((fsel == FS_CAP_R16) && (cap_cnt_ff == CAP_DIV16))
                    || (fsel == FS_CAP_FALL) || (fsel == FS_CAP_RISE));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_prev_ff <= 1'b0;
      cap_cnt_ff  <= '0;
    end else begin
      cap_prev_ff <= cap_in_i;
      if (!is_cap || enter || cap_evt) begin
        cap_cnt_ff <= '0;
      end else if (cap_edge) begin
        cap_cnt_ff <= cap_cnt_ff + 4'h1;
      end
    end
  end

  // Capture/compare word: captured timer, or software bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ccpr_ff <= WORD_RST;
    end else if (cap_evt) begin
      ccpr_ff <= sel_cnt;
    end else if (wr && (adr_i == ADR_CCPR)) begin
      if (sel_i[SEL_LO]) begin
        ccpr_ff[7:0] <= dat_i[7:0];
      end
      if (sel_i[SEL_HI]) begin
        ccpr_ff[15:8] <= dat_i[15:8];
      end
    end
  end

  // Period timer: 8-bit period plus two phase bits for 10-bit duty
  assign per_end = (tmr10_ff[9:2] == per_ff) && (tmr10_ff[1:0] == PH_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr10_ff <= '0;
    end else if (!is_pwm || per_end) begin
      tmr10_ff <= '0;
    end else begin
      tmr10_ff <= tmr10_ff + 10'h001;
    end
  end

  // Duty latched at each period start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_lat_ff <= '0;
    end else if (is_pwm && (per_end || (pwm_st_ff == PS_IDLE))) begin
      duty_lat_ff <= {duty_ff, ctrl_ff[DUTY_HI:DUTY_LO]};
    end
  end

  // PWM start-up: wait for a whole period before driving
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_st_ff <= PS_IDLE;
    end else begin
      case (pwm_st_ff)
        PS_IDLE: begin
          if (is_pwm) begin
            pwm_st_ff <= PS_WAIT;
          end
        end
        PS_WAIT: begin
          if (!is_pwm) begin
            pwm_st_ff <= PS_IDLE;
          end else if (per_end) begin
            pwm_st_ff <= PS_RUN;
          end
        end
        default: begin
          if (!is_pwm) begin
            pwm_st_ff <= PS_IDLE;
          end
        end
      endcase
    end
  end

  // Modulated and active levels, both inactive until running
  assign act = (pwm_st_ff == PS_RUN);
  assign mod = act && (tmr10_ff < duty_lat_ff);

  // Pin mapping per function and output configuration
  always_comb begin
    nxt_out = '0;
    nxt_own = '0;
    if (ctrl_ff == CTRL_RST) begin
      nxt_own = '0;
    end else if (!is_pwm) begin
      nxt_out[0] = cmp_pin_ff;
      nxt_own[0] = (fsel == FS_TOGGLE) || (fsel == FS_CMP_SET) || (fsel == FS_CMP_CLR);
    end else begin
      case (ocfg)
        OC_SINGLE: begin
          nxt_out = {4{mod}};
          nxt_own = steer_ff;
        end
        OC_FWD: begin
          nxt_out = {mod, 1'b0, 1'b0, act};
          nxt_own = 4'hF;
        end
        OC_HALF: begin
          nxt_out = {2'h0, act && !mod, mod};
          nxt_own = 4'h3;
        end
        default: begin
          nxt_out = {1'b0, act, mod, 1'b0};
          nxt_own = 4'hF;
        end
      endcase
      // Active-low selection per pin pair
      nxt_out[0] = nxt_out[0] ^ fsel[POL_AC];
      nxt_out[2] = nxt_out[2] ^ fsel[POL_AC];
      nxt_out[1] = nxt_out[1] ^ fsel[POL_BD];
      nxt_out[3] = nxt_out[3] ^ fsel[POL_BD];
    end
  end

  // Registered pin drivers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_ff <= '0;
      own_ff <= '0;
    end else begin
      out_ff <= nxt_out;
      own_ff <= nxt_own;
    end
  end

  assign out_a_o = out_ff[0];
  assign out_b_o = out_ff[1];
  assign out_c_o = out_ff[2];
  assign out_d_o = out_ff[3];
  assign own_a_o = own_ff[0];
  assign own_b_o = own_ff[1];
  assign own_c_o = own_ff[2];
  assign own_d_o = own_ff[3];

  // Sticky status, write one to clear, set wins
  assign ist_set[IST_UNIT] = cap_evt || match;
  assign ist_set[IST_PER]  = is_pwm && per_end;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_ff <= '0;
    end else if (wr && sel_i[SEL_LO] && (adr_i == ADR_IST)) begin
      ist_ff <= (ist_ff & ~dat_i[1:0]) | ist_set;
    end else begin
      ist_ff <= ist_ff | ist_set;
    end
  end

  // Level interrupt from unmasked status
  assign irq_o = |(ist_ff & imsk_ff);
endmodule
`default_nettype wire

/* tb/ecm_unit_monitor.sv */
`default_nettype none
module ecm_unit_monitor
  import ecm_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // Pins and event
  input wire logic        out_a_o,
  input wire logic        out_b_o,
  input wire logic        out_c_o,
  input wire logic        out_d_o,
  input wire logic        own_a_o,
  input wire logic        own_b_o,
  input wire logic        own_c_o,
  input wire logic        own_d_o,
  input wire logic        spev_o
);
  logic       wr_c;
  logic [3:0] own;
  // Control write taken at the ack edge
  assign wr_c = cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == ADR_CTRL;
  assign own  = {own_d_o, own_c_o, own_b_o, own_a_o};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Control lands at the ack edge, claims show two edges on, the compare pin one more
  a_cmp_set_pins: assert property (wr_c && dat_i[3:0] == FS_CMP_SET |-> ##2 own == 4'h1 ##1 !out_a_o)
    else $error("compare set pins wrong");
  a_cmp_clr_pins: assert property (wr_c && dat_i[3:0] == FS_CMP_CLR |-> ##2 own == 4'h1 ##1 out_a_o)
    else $error("compare clear pins wrong");
  a_swi_frees_pin: assert property (wr_c && dat_i[3:1] == 3'h5 |-> ##2 own == 4'h0)
    else $error("pin kept in event compare");
  a_zero_releases: assert property (wr_c && dat_i[7:0] == 8'h00 |-> ##2 own == 4'h0)
    else $error("pins kept after clear");
  a_fwd_pins: assert property (wr_c && dat_i[7:6] == OC_FWD && dat_i[3:0] == 4'hC
    |-> ##2 own == 4'hF && !out_b_o && !out_c_o) else $error("forward pins wrong");
  a_half_pins: assert property (wr_c && dat_i[7:6] == OC_HALF && dat_i[3:2] == FS_PWM_TOP
    |-> ##2 own == 4'h3) else $error("half bridge claim wrong");
  a_rev_pins: assert property (wr_c && dat_i[7:6] == OC_REV && dat_i[3:0] == 4'hC
    |-> ##2 own == 4'hF && !out_a_o && !out_d_o) else $error("reverse pins wrong");
  a_spev_pulse: assert property (spev_o |=> !spev_o)
    else $error("event pulse too long");
endmodule
bind ecm_unit ecm_unit_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .out_a_o(out_a_o),
  .out_b_o(out_b_o), .out_c_o(out_c_o), .out_d_o(out_d_o), .own_a_o(own_a_o), .own_b_o(own_b_o),
  .own_c_o(own_c_o), .own_d_o(own_d_o), .spev_o(spev_o));
`default_nettype wire

/* tb/ecm_load_model.sv */
`default_nettype none
module ecm_load_model (
  // Unit side
  input  wire logic [3:0] own_i,
  input  wire logic [3:0] out_i,
  // Port side drive and pin level
  input  wire logic [3:0] port_i,
  output logic      [3:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Claimed pins carry the unit value, others the port latch
  assign pin_o = (own_i & out_i) | (~own_i & port_i);
endmodule
`default_nettype wire

/* tb/test_ecm_unit.sv */
`default_nettype none
module test_ecm_unit
  import ecm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i, cyc_i, stb_i, we_i, ack_o, spev_o, irq_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, port, pin;
  wire logic [3:0] out, own;
  logic [31:0] dat_i, dat_o, v;
  logic [7:0]  md [6] = '{8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h8C, 8'hCC};
  int          fail_count = 0;
  int          n_compared = 0;
  int          i, hi, lo;
  // Clock
  always #50 clk_i = ~clk_i;
  ecm_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cap_in_i(pin[0]), .out_a_o(out[0]),
    .out_b_o(out[1]), .out_c_o(out[2]), .out_d_o(out[3]), .own_a_o(own[0]), .own_b_o(own[1]),
    .own_c_o(own[2]), .own_d_o(own[3]), .spev_o(spev_o), .irq_o(irq_o));
  ecm_load_model i_load (.own_i(own), .out_i(out), .port_i(port), .pin_o(pin));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One classic bus cycle, read data left in v
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    chk("ack", ack_o, 1);
    v = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  task automatic wait_run;
    for (i = 0; i < 60; i++) begin
      wb(0, ADR_STAT, 0);
      if (v[11] === 1'b1)
        break;
    end
    chk("running", v[11], 1);
  endtask
  task automatic t_regs;
    wb(0, ADR_PER, 0);
    chk("period", v, 32'hFF);
    wb(0, ADR_STEER, 0);
    chk("steering", v, 32'h1);
    wb(1, 8'h40, 32'hFF);
    wb(0, 8'h40, 0);
    chk("unmapped", v, 0);
    wb(1, ADR_CTRL, 32'h30);
    wb(0, ADR_CTRL, 0);
    chk("control", v, 32'h30);
    tick;
    chk("off pins", own, 0);
    $display("regs done");
  endtask
  task automatic t_single;
    wb(1, ADR_PER, 3);
    wb(1, ADR_DUTY, 2);
    wb(1, ADR_STEER, 5);
    wb(1, ADR_CTRL, 32'h2C);
    tick;
    chk("steered", own, 4'h5);
    chk("early", out[0], 0);
    wait_run;
    for (i = 0; i < 40 && out[0] !== 1'b0; i++) tick;
    for (i = 0; i < 40 && out[0] !== 1'b1; i++) tick;
    hi = 0;
    while (out[0] === 1'b1 && hi < 40) begin
      hi++;
      tick;
    end
    lo = 0;
    while (out[0] === 1'b0 && lo < 40) begin
      lo++;
      tick;
    end
    chk("duty", hi, 10);
    chk("period", hi + lo, 16);
    chk("pin c", out[2], 1);
    chk("pin b", pin[1], 0);
    $display("single done");
  endtask
  task automatic t_bridge;
    for (int k = 0; k < 6; k++) begin
      wb(1, ADR_CTRL, 0);
      tick;
      chk("release", own, 0);
      wb(1, ADR_CTRL, md[k]);
      wait_run;
      repeat (8) tick;
      chk("claim", own, md[k][7:6] == OC_HALF ? 4'h3 : 4'hF);
      case (md[k][7:6])
        OC_FWD: begin
          chk("fwd a", out[0], !md[k][1]);
          chk("fwd b", out[1], md[k][0]);
          chk("fwd c", out[2], md[k][1]);
        end
        OC_REV: begin
          chk("rev c", out[2], 1);
          chk("rev a", out[0] | out[3], 0);
        end
        default: begin
          repeat (20) begin
            tick;
            chk("complement", out[1] !== out[0], 1);
          end
        end
      endcase
    end
    $display("bridge done");
  endtask
  task automatic t_compare;
    wb(1, ADR_CTRL, 0);
    wb(1, ADR_TCFG, 2);
    wb(1, ADR_IMSK, 1);
    wb(1, ADR_IST, 3);
    wb(1, ADR_CCPR, 32'h30);
    wb(1, ADR_FIRST_CAPTURE_TIMER, 0);
    wb(1, ADR_CTRL, 32'hC8);
    tick;
    tick;
    chk("init low", {own, out}, 8'h10);
    for (i = 0; i < 200 && out[0] !== 1'b1; i++) tick;
    chk("match set", out[0], 1);
    chk("irq", irq_o, 1);
    wb(1, ADR_IMSK, 0);
    tick;
    chk("masked", irq_o, 0);
    wb(1, ADR_IMSK, 1);
    wb(1, ADR_IST, 1);
    tick;
    chk("cleared", irq_o, 0);
    wb(1, ADR_CTRL, 0);
    wb(1, ADR_FIRST_CAPTURE_TIMER, 0);
    wb(1, ADR_CTRL, 32'h49);
    tick;
    tick;
    chk("init high", out[0], 1);
    for (i = 0; i < 200 && out[0] !== 1'b0; i++) tick;
    chk("match clear", out[0], 0);
    wb(0, ADR_IST, 0);
    chk("flag", v[0], 1);
    $display("compare done");
  endtask
  task automatic t_spev;
    wb(1, ADR_CTRL, 32'h0B);
    for (int k = 0; k < 2; k++) begin
      wb(1, ADR_TCFG, k ? 5 : 2);
      wb(1, k ? ADR_TMR2 : ADR_FIRST_CAPTURE_TIMER, 0);
      for (i = 0; i < 200 && spev_o !== 1'b1; i++) tick;
      chk("event", spev_o, 1);
      wb(0, k ? ADR_TMR2 : ADR_FIRST_CAPTURE_TIMER, 0);
      chk("timer reset", v[15:0] < 16'h8, 1);
    end
    chk("no claim", own, 0);
    $display("event done");
  endtask
  // Watchdog
  initial begin
    #1000000;
    fail_count++;
    final_report;
  end
  // Main sequence
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h3;
    dat_i = 32'h0;
    port = 4'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_single;
    t_bridge;
    t_compare;
    t_spev;
    final_report;
  end
endmodule
`default_nettype wire
